/* File: cpat_pkg.sv */
/*
  Shared constants and types for the codec pin, clock and AGC timing registers.
  Assumes an 8-bit register port with 7-bit addresses in the digital clock domain.
*/
package cpat_pkg;

  // ==========================================================
  // Register offsets and reset values
  localparam logic [6:0] ADDR_PIN = 7'h65;
  localparam logic [6:0] ADDR_CLK = 7'h66;
  localparam logic [6:0] ADDR_ATK = 7'h67;
  localparam logic [6:0] ADDR_DCY = 7'h68;
  localparam logic [7:0] RST_PIN = 8'h00;
  localparam logic [7:0] RST_CLK = 8'h02;
  localparam logic [7:0] RST_ATK = 8'h00;
  localparam logic [7:0] RST_DCY = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // Writable bits of the pin register; the rest come from hardware
  localparam logic [7:0] PIN_WR_MASK = 8'h37;

  // ==========================================================
  // Field positions
  localparam int BIT_STRAP0 = 7;
  localparam int BIT_STRAP1 = 6;
  localparam int BIT_GPI_EN = 5;
  localparam int BIT_AUDIO_SERIAL_IN_EN = 4;
  localparam int BIT_GPI_VAL = 3;
  localparam int BIT_GPO_EN = 2;
  localparam int BIT_GPO_LVL = 1;
  localparam int BIT_CORE_SEL = 0;
  localparam int DIV_SRC_HI = 7;
  localparam int DIV_SRC_LO = 6;
  localparam int PLL_SRC_HI = 5;
  localparam int PLL_SRC_LO = 4;
  localparam int PLL_N_HI = 3;
  localparam int PLL_N_LO = 0;
  localparam int T_SRC = 7;
  localparam int T_BASE_HI = 6;
  localparam int T_BASE_LO = 5;
  localparam int T_MULT_HI = 4;
  localparam int T_MULT_LO = 2;

  // ==========================================================
  // Encodings and tables
  localparam logic [1:0] SRC_MCLK = 2'h0;
  localparam logic [1:0] SRC_SECOND_GPIO_PIN = 2'h1;
  localparam logic [1:0] SRC_BCLK = 2'h2;
  localparam logic [3:0] PLL_N_CODE16 = 4'h0;
  localparam logic [3:0] PLL_N_CODE17 = 4'h1;
  localparam logic [4:0] PLL_N_16 = 5'h10;
  localparam logic [4:0] PLL_N_17 = 5'h11;
  localparam logic [15:0] ATK_BASE_MS [4] = '{16'h0007, 16'h0008, 16'h000a, 16'h000b};
  localparam logic [15:0] DCY_BASE_MS [4] = '{16'h0032, 16'h0096, 16'h00fa, 16'h015e};
  // Decay cap in ms, indexed by twice the decimation ratio
  localparam logic [15:0] DCY_CAP_MS [16] = '{
    16'h5780, 16'h5780, 16'h0fa0, 16'h15e0, 16'h1f40, 16'h2580, 16'h2bc0, 16'h2bc0,
    16'h3e80, 16'h3e80, 16'h4b00, 16'h5780, 16'h5780, 16'h5780, 16'h5780, 16'h5780};
  // Cycles the pin synchroniser needs before a strap is trusted
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {ST_WAIT = 2'b01, ST_DONE = 2'b10} cpat_strap_st_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } cpat_req_t;

  typedef struct packed {
    logic gpi_en;
    logic audio_serial_in_route;
    logic core_clk_sel;
  } cpat_pin_cfg_t;

  typedef struct packed {
    logic [1:0] div_src;
    logic [1:0] pll_src;
    logic [4:0] pll_n;
  } cpat_clk_cfg_t;

  typedef struct packed {
    logic use_new;
    logic [15:0] time_ms;
  } cpat_agc_time_t;

endpackage

/* File: cpat_sync.sv */
/*
  Three-stage pin synchroniser with agreement filter.
  Assumes asynchronous pins and the shared clock enable of the register bank.
*/
`timescale 1ns/1ns
`default_nettype none

module cpat_sync #(
  parameter int W = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  // ==========================================================
  // Stages
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else if (ce_i) begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // ==========================================================
  // Agreement filter: a level counts once stages two and three match
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic q_reg;
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          q_reg <= 1'b0;
        end else if (ce_i && (s2_reg[g] == s3_reg[g])) begin
          q_reg <= s3_reg[g];
        end
      end
      assign q_o[g] = q_reg;
    end
  endgenerate

endmodule

`default_nettype wire

/* File: cpat_regs.sv */
/*
  Pin strap, clock source and left AGC timing register bank of the codec.
  Assumes a host register port already decoded from the control bus, pins
  asynchronous to clk_i, and the decimation ratio on the same clock.
*/
//
// Behaviour
// - D7 reports strap zero level from reset
// - D6 reports strap one level from reset
// - D5 enables third pin general input
// - D4 routes third pin to serial data
// - D3 reads third pin input level
// - D2 enables second pin general output
// - D1 sets second pin output level
// - D7-D1 act only when select pin low
// - D0 picks core clock divider source
// - D7-D6 pick plain divider input source
// - D5-D4 pick PLL reference input source
// - PLL N decodes 0 to 16, 1 to 17
// - Attack D7 picks legacy or new source
// - Attack baseline codes give 7/8/10/11 ms
// - Attack multiplier scales by two to field
// - Decay D7 picks legacy or new source
// - Decay baseline codes give 50..350 ms
// - Decay multiplier scales by two to field
// - Decay time capped by decimation ratio
`timescale 1ns/1ns
`default_nettype none

module cpat_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire cpat_pkg::cpat_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  input wire logic ctrl_if_select_i,
  input wire logic multifunc_pin_zero_i,
  input wire logic multifunc_pin_one_i,
  input wire logic multifunc_pin_three_i,
  output logic multifunc_pin_two_o,
  output logic multifunc_pin_two_oe_o,
  output logic audio_serial_in_o,
  input wire logic [3:0] adc_decimation_ratio_i,
  output var cpat_pkg::cpat_pin_cfg_t pin_cfg_o,
  output var cpat_pkg::cpat_clk_cfg_t clk_cfg_o,
  output var cpat_pkg::cpat_agc_time_t attack_o,
  output var cpat_pkg::cpat_agc_time_t decay_o
);

  // ==========================================================
  // Time scaler shared by both timing registers, and the PLL N decoder of the clock register
  function automatic logic [15:0] scale_time(input logic [15:0] base, input logic [2:0] mult);
    scale_time = base << mult;
  endfunction

  function automatic logic [4:0] pll_n_decode(input logic [3:0] code);
    if (code == cpat_pkg::PLL_N_CODE16) begin
      pll_n_decode = cpat_pkg::PLL_N_16;
    end else if (code == cpat_pkg::PLL_N_CODE17) begin
      pll_n_decode = cpat_pkg::PLL_N_17;
    end else begin
      pll_n_decode = {1'b0, code};
    end
  endfunction

  // ==========================================================
  // Pin synchronisers
  logic [3:0] pins_q;
  logic sel_q;
  logic pin0_q;
  logic pin1_q;
  logic pin3_q;

  cpat_sync #(.W(4)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i({ctrl_if_select_i, multifunc_pin_zero_i, multifunc_pin_one_i, multifunc_pin_three_i}),
    .q_o(pins_q)
  );

  assign sel_q = pins_q[3];
  assign pin0_q = pins_q[2];
  assign pin1_q = pins_q[1];
  assign pin3_q = pins_q[0];

  // ==========================================================
  // Strap capture
  // Straps are taken once the synchroniser has settled, not at the async edge,
  // so a metastable pin can never land in the status bits.
  cpat_pkg::cpat_strap_st_t st_reg;
  cpat_pkg::cpat_strap_st_t st_next;
  logic [1:0] settle_reg;
  logic strap_zero_reg;
  logic strap_one_reg;
  // The filtered level lands on the edge of the state change, so take it one edge later
  wire strap_take = (st_reg == cpat_pkg::ST_DONE) && (settle_reg == cpat_pkg::STRAP_SETTLE);

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      cpat_pkg::ST_WAIT: begin
        if (settle_reg == cpat_pkg::STRAP_SETTLE) begin
          st_next = cpat_pkg::ST_DONE;
        end
      end
      cpat_pkg::ST_DONE: begin
        st_next = cpat_pkg::ST_DONE;
      end
      default: begin
        st_next = cpat_pkg::ST_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= cpat_pkg::ST_WAIT;
      settle_reg <= 2'h0;
      strap_zero_reg <= 1'b0;
      strap_one_reg <= 1'b0;
    end else if (ce_i) begin
      st_reg <= st_next;
      if (st_reg == cpat_pkg::ST_WAIT && settle_reg != cpat_pkg::STRAP_SETTLE) begin
        settle_reg <= settle_reg + 2'h1;
      end
      if (strap_take) begin
        strap_zero_reg <= pin1_q;
        strap_one_reg <= pin0_q;
        settle_reg <= 2'h0;
      end
    end
  end

  // ==========================================================
  // Register storage and address decode
  logic [7:0] pin_reg;
  logic [7:0] clk_reg;
  logic [7:0] atk_reg;
  logic [7:0] dcy_reg;
  wire hit_pin = reg_req_i.addr == cpat_pkg::ADDR_PIN;
  wire hit_clk = reg_req_i.addr == cpat_pkg::ADDR_CLK;
  wire hit_atk = reg_req_i.addr == cpat_pkg::ADDR_ATK;
  wire hit_dcy = reg_req_i.addr == cpat_pkg::ADDR_DCY;
  wire wr_en = ce_i && reg_req_i.wr;

  // Reserved and source-select bits are stored as written; a reserved source
  // code simply passes through to the clock tree, so the host must avoid it.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_reg <= cpat_pkg::RST_PIN;
      clk_reg <= cpat_pkg::RST_CLK;
      atk_reg <= cpat_pkg::RST_ATK;
      dcy_reg <= cpat_pkg::RST_DCY;
    end else if (wr_en) begin
      if (hit_pin) begin
        pin_reg <= reg_req_i.wdata & cpat_pkg::PIN_WR_MASK;
      end
      if (hit_clk) begin
        clk_reg <= reg_req_i.wdata;
      end
      if (hit_atk) begin
        atk_reg <= reg_req_i.wdata;
      end
      if (hit_dcy) begin
        dcy_reg <= reg_req_i.wdata;
      end
    end
  end

  // ==========================================================
  // Pin control decode
  wire i2c_mode = !sel_q;
  wire gpi_en = pin_reg[cpat_pkg::BIT_GPI_EN] && i2c_mode;
  wire audio_serial_in_en = pin_reg[cpat_pkg::BIT_AUDIO_SERIAL_IN_EN] && i2c_mode;
  wire gpo_en = pin_reg[cpat_pkg::BIT_GPO_EN] && i2c_mode;
  wire gpi_val = pin3_q && gpi_en;
  wire strap_ok = i2c_mode && (st_reg == cpat_pkg::ST_DONE) && !strap_take;

  wire [7:0] pin_rd = {
    strap_zero_reg && strap_ok,
    strap_one_reg && strap_ok,
    gpi_en,
    audio_serial_in_en,
    gpi_val,
    gpo_en,
    pin_reg[cpat_pkg::BIT_GPO_LVL] && i2c_mode,
    pin_reg[cpat_pkg::BIT_CORE_SEL]
  };

  wire [7:0] rd_mux = hit_pin ? pin_rd :
                      hit_clk ? clk_reg :
                      hit_atk ? atk_reg :
                      hit_dcy ? dcy_reg : cpat_pkg::RD_UNMAPPED;

  // ==========================================================
  // AGC time decode
  wire [1:0] atk_base = atk_reg[cpat_pkg::T_BASE_HI:cpat_pkg::T_BASE_LO];
  wire [2:0] atk_mult = atk_reg[cpat_pkg::T_MULT_HI:cpat_pkg::T_MULT_LO];
  wire [1:0] dcy_base = dcy_reg[cpat_pkg::T_BASE_HI:cpat_pkg::T_BASE_LO];
  wire [2:0] dcy_mult = dcy_reg[cpat_pkg::T_MULT_HI:cpat_pkg::T_MULT_LO];
  // Products fit in 16 bits: 350 ms times 128 is the largest
  wire [15:0] atk_ms = scale_time(cpat_pkg::ATK_BASE_MS[atk_base], atk_mult);
  wire [15:0] dcy_raw = scale_time(cpat_pkg::DCY_BASE_MS[dcy_base], dcy_mult);
  wire [15:0] dcy_cap = cpat_pkg::DCY_CAP_MS[adc_decimation_ratio_i];
  wire [15:0] dcy_ms = (dcy_raw > dcy_cap) ? dcy_cap : dcy_raw;

  // ==========================================================
  // Registered outputs
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= cpat_pkg::RD_UNMAPPED;
      multifunc_pin_two_o <= 1'b0;
      multifunc_pin_two_oe_o <= 1'b0;
      audio_serial_in_o <= 1'b0;
      pin_cfg_o <= '0;
      clk_cfg_o <= '0;
      attack_o <= '0;
      decay_o <= '0;
    end else if (ce_i) begin
      if (reg_req_i.rd) begin
        reg_rdata_o <= rd_mux;
      end
      multifunc_pin_two_oe_o <= gpo_en;
      multifunc_pin_two_o <= pin_reg[cpat_pkg::BIT_GPO_LVL] && gpo_en;
      audio_serial_in_o <= pin3_q && audio_serial_in_en;
      pin_cfg_o.gpi_en <= gpi_en;
      pin_cfg_o.audio_serial_in_route <= audio_serial_in_en;
      pin_cfg_o.core_clk_sel <= pin_reg[cpat_pkg::BIT_CORE_SEL];
      clk_cfg_o.div_src <= clk_reg[cpat_pkg::DIV_SRC_HI:cpat_pkg::DIV_SRC_LO];
      clk_cfg_o.pll_src <= clk_reg[cpat_pkg::PLL_SRC_HI:cpat_pkg::PLL_SRC_LO];
      clk_cfg_o.pll_n <= pll_n_decode(clk_reg[cpat_pkg::PLL_N_HI:cpat_pkg::PLL_N_LO]);
      attack_o.use_new <= atk_reg[cpat_pkg::T_SRC];
      attack_o.time_ms <= atk_ms;
      decay_o.use_new <= dcy_reg[cpat_pkg::T_SRC];
      decay_o.time_ms <= dcy_ms;
    end
  end

  // ==========================================================
  // Checks
  property p_strap_zero;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && reg_req_i.rd && hit_pin && strap_ok)
      |=> reg_rdata_o[cpat_pkg::BIT_STRAP0] == strap_zero_reg;
  endproperty
  a_strap_zero: assert property (p_strap_zero) else $error("strap zero status wrong");

  property p_strap_one;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && reg_req_i.rd && hit_pin && strap_ok)
      |=> reg_rdata_o[cpat_pkg::BIT_STRAP1] == strap_one_reg;
  endproperty
  a_strap_one: assert property (p_strap_one) else $error("strap one status wrong");

  property p_gpi_read;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && reg_req_i.rd && hit_pin && !gpi_en)
      |=> !reg_rdata_o[cpat_pkg::BIT_GPI_VAL];
  endproperty
  a_gpi_read: assert property (p_gpi_read) else $error("input value seen while disabled");

  property p_gpo_drive;
    @(posedge clk_i) disable iff (rst_i)
    (wr_en && hit_pin && reg_req_i.wdata[cpat_pkg::BIT_GPO_EN] && i2c_mode)
      ##1 (ce_i && i2c_mode) |=> multifunc_pin_two_oe_o;
  endproperty
  a_gpo_drive: assert property (p_gpo_drive) else $error("output enable not raised");

  property p_spi_mode;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && sel_q) |=> !multifunc_pin_two_oe_o && !pin_cfg_o.gpi_en && !audio_serial_in_o;
  endproperty
  a_spi_mode: assert property (p_spi_mode) else $error("pin use active in SPI mode");

  property p_core_sel;
    @(posedge clk_i) disable iff (rst_i)
    ce_i |=> pin_cfg_o.core_clk_sel == $past(pin_reg[cpat_pkg::BIT_CORE_SEL]);
  endproperty
  a_core_sel: assert property (p_core_sel) else $error("core clock select lags");

  property p_pll_n;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && clk_reg[cpat_pkg::PLL_N_HI:cpat_pkg::PLL_N_LO] == cpat_pkg::PLL_N_CODE17)
      |=> clk_cfg_o.pll_n == cpat_pkg::PLL_N_17;
  endproperty
  a_pll_n: assert property (p_pll_n) else $error("PLL N code one not 17");

  property p_attack_time;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && atk_mult == 3'h7 && atk_base == 2'h3) |=> attack_o.time_ms == 16'h0580;
  endproperty
  a_attack_time: assert property (p_attack_time) else $error("attack time scale wrong");

  property p_decay_cap;
    @(posedge clk_i) disable iff (rst_i)
    ce_i |=> decay_o.time_ms <= $past(dcy_cap) && decay_o.time_ms <= $past(dcy_raw);
  endproperty
  a_decay_cap: assert property (p_decay_cap) else $error("decay time over its cap");

  property p_strap_hold;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && st_reg == cpat_pkg::ST_DONE && !strap_take)
      |=> $stable(strap_zero_reg) && $stable(strap_one_reg);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("strap status moved");

  property p_gpi_enable;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && i2c_mode) |=> pin_cfg_o.gpi_en == $past(pin_reg[cpat_pkg::BIT_GPI_EN]);
  endproperty
  a_gpi_enable: assert property (p_gpi_enable) else $error("input enable not applied");

  property p_audio_serial_in_route;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && audio_serial_in_en) |=> audio_serial_in_o == $past(pin3_q);
  endproperty
  a_audio_serial_in_route: assert property (p_audio_serial_in_route) else $error("serial input not routed");

  property p_gpo_level;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && gpo_en) |=> multifunc_pin_two_o == $past(pin_reg[cpat_pkg::BIT_GPO_LVL]);
  endproperty
  a_gpo_level: assert property (p_gpo_level) else $error("output level wrong");

  property p_div_src;
    @(posedge clk_i) disable iff (rst_i)
    ce_i |=> clk_cfg_o.div_src == $past(clk_reg[cpat_pkg::DIV_SRC_HI:cpat_pkg::DIV_SRC_LO]);
  endproperty
  a_div_src: assert property (p_div_src) else $error("divider source wrong");

  property p_pll_src;
    @(posedge clk_i) disable iff (rst_i)
    ce_i |=> clk_cfg_o.pll_src == $past(clk_reg[cpat_pkg::PLL_SRC_HI:cpat_pkg::PLL_SRC_LO]);
  endproperty
  a_pll_src: assert property (p_pll_src) else $error("PLL reference source wrong");

  property p_pll_n16;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && clk_reg[cpat_pkg::PLL_N_HI:cpat_pkg::PLL_N_LO] == cpat_pkg::PLL_N_CODE16)
      |=> clk_cfg_o.pll_n == cpat_pkg::PLL_N_16;
  endproperty
  a_pll_n16: assert property (p_pll_n16) else $error("PLL N code zero not 16");

  property p_decay_base;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && dcy_mult == 3'h0 && dcy_base == 2'h3) |=> decay_o.time_ms == 16'h015e;
  endproperty
  a_decay_base: assert property (p_decay_base) else $error("decay baseline wrong");

endmodule

`default_nettype wire

/* File: cpat_regs_test.sv */
/*
  Self-checking testbench for the pin strap, clock source and left AGC timing registers.
  Assumes the strobe register port of cpat_regs: read data one edge after the read,
  outputs two edges after a write, straps settled six cycles after reset release.
*/
`timescale 1ns/1ns
`default_nettype none

module cpat_regs_test;
  // ==========================================================
  // Stimulus signals and design under test
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  cpat_pkg::cpat_req_t req = '0;
  logic sel = 1'b0;
  logic pin0 = 1'b0;
  logic pin1 = 1'b1;
  logic pin3 = 1'b0;
  logic [3:0] ratio = 4'h2;
  logic [7:0] rdata;
  logic pin2;
  logic pin2_oe;
  logic audio_serial_in;
  cpat_pkg::cpat_pin_cfg_t pin_cfg;
  cpat_pkg::cpat_clk_cfg_t clk_cfg;
  cpat_pkg::cpat_agc_time_t atk;
  cpat_pkg::cpat_agc_time_t dcy;
  int mismatches = 0;
  int total_checks = 0;
  logic [7:0] v;
  logic [15:0] exp_t;
  int exp_n;

  always #20 clk_i = ~clk_i;

  cpat_regs i_dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .reg_req_i(req),
    .reg_rdata_o(rdata),
    .ctrl_if_select_i(sel),
    .multifunc_pin_zero_i(pin0),
    .multifunc_pin_one_i(pin1),
    .multifunc_pin_three_i(pin3),
    .multifunc_pin_two_o(pin2),
    .multifunc_pin_two_oe_o(pin2_oe),
    .audio_serial_in_o(audio_serial_in),
    .adc_decimation_ratio_i(ratio),
    .pin_cfg_o(pin_cfg),
    .clk_cfg_o(clk_cfg),
    .attack_o(atk),
    .decay_o(dcy)
  );

  // ==========================================================
  // Expected values
  function automatic logic [15:0] atk_base(input logic [1:0] c);
    case (c)
      2'h0: return 16'h0007;
      2'h1: return 16'h0008;
      2'h2: return 16'h000a;
      default: return 16'h000b;
    endcase
  endfunction

  function automatic logic [15:0] dcy_base(input logic [1:0] c);
    case (c)
      2'h0: return 16'h0032;
      2'h1: return 16'h0096;
      2'h2: return 16'h00fa;
      default: return 16'h015e;
    endcase
  endfunction

  // Input carries twice the ratio, so half ratios get their own codes
  function automatic logic [15:0] dcy_cap(input logic [3:0] r);
    case (r)
      4'h2: return 16'h0fa0;
      4'h3: return 16'h15e0;
      4'h4: return 16'h1f40;
      4'h5: return 16'h2580;
      4'h6, 4'h7: return 16'h2bc0;
      4'h8, 4'h9: return 16'h3e80;
      4'ha: return 16'h4b00;
      default: return 16'h5780;
    endcase
  endfunction

  // ==========================================================
  // Port tasks, entered and left just after a falling edge
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_test(input string name);
    $display("test %s done, %0d mismatches so far", name, mismatches);
  endtask

  // Two extra edges let the write reach the decoded outputs
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge clk_i);
    req = '0;
    repeat (2) @(negedge clk_i);
  endtask

  task automatic rd_chk(input string what, input logic [6:0] a, input logic [7:0] exp);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk_i);
    req = '0;
    @(negedge clk_i);
    chk(what, 16'(exp), 16'(rdata));
  endtask

  task automatic do_reset();
    rst_i = 1'b1;
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (6) @(negedge clk_i);
  endtask

  // ==========================================================
  // Watchdog: every wait below is a fixed count, this only catches a stuck run
  initial begin
    repeat (100000) @(posedge clk_i);
    mismatches++;
    $display("mismatch run length expected finish seen timeout");
    wrap_up();
  end

  // ==========================================================
  // Main sequence
  initial begin
    do_reset();
    rd_chk("pin reg", cpat_pkg::ADDR_PIN, 8'h80);
    rd_chk("clk reg", cpat_pkg::ADDR_CLK, 8'h02);
    chk("pll n", 16'h0002, 16'(clk_cfg.pll_n));
    rd_chk("atk reg", cpat_pkg::ADDR_ATK, 8'h00);
    rd_chk("dcy reg", cpat_pkg::ADDR_DCY, 8'h00);
    chk("atk time", 16'h0007, atk.time_ms);
    chk("dcy time", 16'h0032, dcy.time_ms);
    wr(7'h69, 8'hff);
    rd_chk("unmapped", 7'h69, 8'h00);
    ce_i = 1'b0;
    wr(cpat_pkg::ADDR_ATK, 8'hfc);
    ce_i = 1'b1;
    rd_chk("atk frozen", cpat_pkg::ADDR_ATK, 8'h00);
    end_test("reset");

    pin3 = 1'b1;
    wr(cpat_pkg::ADDR_PIN, 8'hff);
    repeat (4) @(negedge clk_i);
    rd_chk("pin all", cpat_pkg::ADDR_PIN, 8'hbf);
    chk("gpi en", 16'h0001, 16'(pin_cfg.gpi_en));
    chk("audio_serial_in route", 16'h0001, 16'(pin_cfg.audio_serial_in_route));
    chk("audio_serial_in", 16'h0001, 16'(audio_serial_in));
    chk("gpo oe", 16'h0001, 16'(pin2_oe));
    chk("gpo lvl", 16'h0001, 16'(pin2));
    chk("core sel", 16'h0001, 16'(pin_cfg.core_clk_sel));
    pin3 = 1'b0;
    repeat (6) @(negedge clk_i);
    rd_chk("pin low", cpat_pkg::ADDR_PIN, 8'hb7);
    chk("audio_serial_in low", 16'h0000, 16'(audio_serial_in));
    wr(cpat_pkg::ADDR_PIN, 8'h02);
    rd_chk("pin lvl only", cpat_pkg::ADDR_PIN, 8'h82);
    chk("gpo off", 16'h0000, 16'(pin2_oe));
    chk("gpi off", 16'h0000, 16'(pin_cfg.gpi_en));
    chk("core pll", 16'h0000, 16'(pin_cfg.core_clk_sel));
    wr(cpat_pkg::ADDR_PIN, 8'h35);
    chk("gpo on", 16'h0001, 16'(pin2_oe));
    chk("gpo low", 16'h0000, 16'(pin2));
    // Select high turns every pin use off but keeps the clock choice
    sel = 1'b1;
    repeat (6) @(negedge clk_i);
    rd_chk("pin spi", cpat_pkg::ADDR_PIN, 8'h01);
    chk("spi gpi", 16'h0000, 16'(pin_cfg.gpi_en));
    chk("spi audio_serial_in", 16'h0000, 16'(pin_cfg.audio_serial_in_route));
    chk("spi oe", 16'h0000, 16'(pin2_oe));
    chk("spi core", 16'h0001, 16'(pin_cfg.core_clk_sel));
    sel = 1'b0;
    repeat (6) @(negedge clk_i);
    rd_chk("pin i2c", cpat_pkg::ADDR_PIN, 8'hb5);
    end_test("pins");

    for (int d = 0; d < 3; d++) begin
      for (int p = 0; p < 3; p++) begin
        for (int n = 0; n < 16; n++) begin
          v = {2'(d), 2'(p), 4'(n)};
          exp_n = (n == 0) ? 16 : (n == 1) ? 17 : n;
          wr(cpat_pkg::ADDR_CLK, v);
          chk("div src", 16'(d), 16'(clk_cfg.div_src));
          chk("pll src", 16'(p), 16'(clk_cfg.pll_src));
          chk("pll n", 16'(exp_n), 16'(clk_cfg.pll_n));
          rd_chk("clk reg", cpat_pkg::ADDR_CLK, v);
        end
      end
    end
    end_test("clock");

    for (int i = 0; i < 64; i++) begin
      v = {i[5], i[4:3], i[2:0], 2'b00};
      ratio = 4'(i % 16);
      wr(cpat_pkg::ADDR_ATK, v);
      wr(cpat_pkg::ADDR_DCY, v);
      chk("atk src", 16'(v[7]), 16'(atk.use_new));
      chk("atk time", atk_base(v[6:5]) << v[4:2], atk.time_ms);
      exp_t = dcy_base(v[6:5]) << v[4:2];
      if (exp_t > dcy_cap(ratio)) begin
        exp_t = dcy_cap(ratio);
      end
      chk("dcy src", 16'(v[7]), 16'(dcy.use_new));
      chk("dcy time", exp_t, dcy.time_ms);
      rd_chk("atk reg", cpat_pkg::ADDR_ATK, v);
      rd_chk("dcy reg", cpat_pkg::ADDR_DCY, v);
    end
    end_test("agc");

    // Mid-run reset with straps swapped; the captured level must not follow the pin later
    pin1 = 1'b0;
    pin0 = 1'b1;
    do_reset();
    rd_chk("strap one", cpat_pkg::ADDR_PIN, 8'h40);
    rd_chk("clk again", cpat_pkg::ADDR_CLK, 8'h02);
    pin0 = 1'b0;
    pin1 = 1'b1;
    repeat (6) @(negedge clk_i);
    rd_chk("strap held", cpat_pkg::ADDR_PIN, 8'h40);
    end_test("second reset");
    wrap_up();
  end
endmodule

`default_nettype wire
